// [src/fstp_defines.vh]
// constants for the frame start timestamp pulse block
// assumes a 250 MHz system clock and a 32-bit ahb-lite register port
`ifndef FSTP_DEFINES_VH
`define FSTP_DEFINES_VH

// clock and timing
`define FSTP_CLK_PERIOD_NS   4
`define FSTP_PHASE_STEP_NS   8
`define FSTP_PHASE_STEP_CYC  ((`FSTP_PHASE_STEP_NS + `FSTP_CLK_PERIOD_NS - 1) / `FSTP_CLK_PERIOD_NS)

// register indexes; byte address is four times the index
`define FSTP_IDX_CTRL        10'h01F
`define FSTP_IDX_SKEW        10'h055
`define FSTP_IDX_SYNC        10'h0E9
`define FSTP_IDX_MUX1        10'h171
`define FSTP_IDX_MUX2        10'h172
`define FSTP_IDX_PHASE       10'h180

// field positions and values
`define FSTP_RESTART_BIT     14
`define FSTP_SYNC_INIT_VAL   16'hDF22
`define FSTP_SKEW_VALID_BIT  15
`define FSTP_SKEW_MST_LSB    4
`define FSTP_SKEW_SLV_LSB    0
`define FSTP_PHASE_TX_LSB    0
`define FSTP_PHASE_RX_LSB    4

// pin mux field codes, four bits per pin
`define FSTP_MUX_OFF         4'h0
`define FSTP_MUX_TX          4'h1
`define FSTP_MUX_RX          4'h2
`define FSTP_MUX_BOTH        4'h3

// reset values
`define FSTP_RST_REG16       16'h0000
`endif

// [src/fstp_phase_delay.v]
// delays a one-cycle frame start strobe by a programmable number of phase steps
// assumes strobes are spaced further apart than the longest delay
`include "fstp_defines.vh"

module fstp_phase_delay #(
	parameter PHASE_W = 4,
	parameter CNT_W   = 8
) (
	// clock and reset
	input  wire               sys_clk_i,
	input  wire               sys_rst_i,
	// strobe in, phase setting
	input  wire               strobe_i,
	input  wire [PHASE_W-1:0] phase_i,
	// delayed strobe
	output wire               pulse_o
);

	reg [CNT_W-1:0] cnt_r;
	reg             busy_r;
	reg             pulse_r;
	wire [CNT_W-1:0] load_w;
	wire [31:0]      load_full_w;

	// product is formed at full width, then cut to the counter on purpose
	assign load_full_w = phase_i * `FSTP_PHASE_STEP_CYC;
	assign load_w      = load_full_w[CNT_W-1:0];
	assign pulse_o = pulse_r;

	////////////////////////////////////////////////////////////////////////////////
	// a new strobe restarts the count so only one pulse leaves per frame
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			cnt_r   <= {CNT_W{1'b0}};
			busy_r  <= 1'b0;
			pulse_r <= 1'b0;
		end else begin
			pulse_r <= 1'b0;
			if (strobe_i) begin
				if (phase_i == {PHASE_W{1'b0}}) begin
					busy_r  <= 1'b0;
					pulse_r <= 1'b1;
				end else begin
					busy_r <= 1'b1;
					cnt_r  <= load_w;
				end
			end else if (busy_r) begin
				cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
				if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1}) begin
					busy_r  <= 1'b0;
					pulse_r <= 1'b1;
				end
			end
		end
	end

endmodule // fstp_phase_delay

// [src/fstp_pin_mux.v]
// routes the two frame start pulses onto eight output pins
// assumes two 16-bit select words, four bits per pin
`include "fstp_defines.vh"

module fstp_pin_mux (
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        sys_rst_i,
	// select words
	input  wire [15:0] sel_first_i,
	input  wire [15:0] sel_second_i,
	input  wire        first_en_i,
	// pulses
	input  wire        tx_pulse_i,
	input  wire        rx_pulse_i,
	// pins
	output wire [7:0]  pins_o
);

	reg [7:0]  pins_r;
	wire [31:0] sel_w;
	integer    i;

	function pick;
		input [3:0] code;
		input       tx;
		input       rx;
		begin
			case (code)
				`FSTP_MUX_TX:   pick = tx;
				`FSTP_MUX_RX:   pick = rx;
				`FSTP_MUX_BOTH: pick = tx | rx;
				default:        pick = 1'b0;
			endcase
		end
	endfunction

	// small package: first word absent, its pins stay low
	assign sel_w  = {sel_second_i, first_en_i ? sel_first_i : 16'h0000};
	assign pins_o = pins_r;

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			pins_r <= 8'h00;
		end else begin
			for (i = 0; i < 8; i = i + 1) begin
				pins_r[i] <= pick(sel_w[i*4 +: 4], tx_pulse_i, rx_pulse_i);
			end
		end
	end

endmodule // fstp_pin_mux

// [src/fstp_top.v]
// frame start timestamp pulse block: pulses, phase, pin routing, skew report
// assumes ahb-lite master on sys_clk_i; line events synchronous to sys_clk_i
//
// Overview of operation
// - separate frame start pulse on receive path and on transmit path.
// - transmit pulse when delimiter hits line; receive pulse at first symbol.
// - register phase value delays each pulse, one 8 ns step per unit.
// - two pin mux registers at 0x171 and 0x172 route pulses to pins.
// - small package variant implements only the second mux register.
// - skew is limited and reported only at 1000 Mb speed.
// - skew may change per new link, stays fixed during one link.
// - skew report valid only after that write and a following new link.
// - bit 14 of register 0x1F restarts the link, forming a new link.
// - master mode skew reported in bits 7:4 of 0x55, 8 ns units.
// - slave mode skew reported in bits 3:0 of 0x55, 8 ns units.
// - at 100 Mb no skew readout is given.
//
// The implementer's own choice: register access over AHB-Lite.
`include "fstp_defines.vh"

module fstp_top #(
	parameter SMALL_PKG  = 0,
	parameter SKEW_LIMIT = 4'hF
) (
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        sys_rst_i,
	// ahb-lite slave
	input  wire        hsel_i,
	input  wire [31:0] haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output wire [31:0] hrdata_o,
	output wire        hreadyout_o,
	output wire        hresp_o,
	// line side events and link state
	input  wire        transmit_frame_start_pulse_line_i,
	input  wire        receive_frame_start_pulse_line_i,
	input  wire        link_up_i,
	input  wire        speed_1000_i,
	input  wire        master_mode_i,
	input  wire [3:0]  align_skew_i,
	// pulses, pins, link control
	output wire        transmit_frame_start_pulse_o,
	output wire        receive_frame_start_pulse_o,
	output wire [7:0]  sfd_pins_o,
	output wire        link_restart_o
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	// bus data phase
	reg         dp_valid_r;
	reg         dp_write_r;
	reg  [9:0]  dp_idx_r;
	reg         dp_hi_ok_r;
	reg         rd_wait_r;
	reg  [31:0] hrdata_r;
	wire        addr_accept_w;
	wire        wr_en_w;

	// software registers
	reg  [15:0] ctrl_r;
	reg  [15:0] sync_ctrl_r;
	reg  [15:0] mux_first_r;
	reg  [15:0] mux_second_r;
	reg  [7:0]  phase_r;
	reg         restart_r;

	// skew tracking
	reg         sync_init_r;
	reg         sync_pending_r;
	reg         link_up_d_r;
	reg         skew_valid_r;
	reg         skew_master_r;
	reg  [3:0]  skew_val_r;
	reg  [15:0] skew_status_nxt;
	wire        link_rise_w;
	wire [3:0]  skew_lim_w;

	// frame start edges
	reg         tx_line_d_r;
	reg         rx_line_d_r;
	wire        tx_strobe_w;
	wire        rx_strobe_w;
	wire        tx_pulse_w;
	wire        rx_pulse_w;

	function hit;
		input [9:0] idx;
		input [9:0] want;
		input       hi_ok;
		begin
			hit = hi_ok & (idx == want);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave: writes take no wait state, reads take one so that the
	// read data comes from a flop and always sees a preceding write

	assign addr_accept_w = hsel_i & htrans_i[1] & hready_i;
	assign wr_en_w       = dp_valid_r & dp_write_r;
	assign hreadyout_o   = ~rd_wait_r;
	assign hresp_o       = 1'b0;
	assign hrdata_o      = hrdata_r;
	// hsize_i, htrans_i[0] and haddr_i[1:0] are not looked at: every register is
	// one aligned word, so narrow or sequential accesses act as word accesses

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			dp_valid_r <= 1'b0;
			dp_write_r <= 1'b0;
			dp_idx_r   <= 10'h000;
			dp_hi_ok_r <= 1'b0;
			rd_wait_r  <= 1'b0;
		end else begin
			// a stalled data phase keeps the captured address and direction
			if (hready_i) begin
				dp_valid_r <= addr_accept_w;
				dp_write_r <= hwrite_i;
				dp_idx_r   <= haddr_i[11:2];
				dp_hi_ok_r <= (haddr_i[31:12] == 20'h0_0000);
				rd_wait_r  <= addr_accept_w & ~hwrite_i;
			end else begin
				rd_wait_r  <= 1'b0;
			end
		end
	end

	// unmapped reads return zero
	// status bit 15 flags a figure taken on an armed 1000 Mb link
	always @* begin
		skew_status_nxt = 16'h0000;
		if (skew_valid_r & speed_1000_i) begin
			skew_status_nxt[`FSTP_SKEW_VALID_BIT] = 1'b1;
			if (skew_master_r) begin
				skew_status_nxt[`FSTP_SKEW_MST_LSB +: 4] = skew_val_r;
			end else begin
				skew_status_nxt[`FSTP_SKEW_SLV_LSB +: 4] = skew_val_r;
			end
		end
	end

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_wait_r) begin
			if (hit(dp_idx_r, `FSTP_IDX_CTRL, dp_hi_ok_r)) begin
				hrdata_r <= {16'h0000, ctrl_r};
			end else if (hit(dp_idx_r, `FSTP_IDX_SKEW, dp_hi_ok_r)) begin
				hrdata_r <= {16'h0000, skew_status_nxt};
			end else if (hit(dp_idx_r, `FSTP_IDX_SYNC, dp_hi_ok_r)) begin
				hrdata_r <= {16'h0000, sync_ctrl_r};
			end else if (hit(dp_idx_r, `FSTP_IDX_MUX1, dp_hi_ok_r) && SMALL_PKG == 0) begin
				hrdata_r <= {16'h0000, mux_first_r};
			end else if (hit(dp_idx_r, `FSTP_IDX_MUX2, dp_hi_ok_r)) begin
				hrdata_r <= {16'h0000, mux_second_r};
			end else if (hit(dp_idx_r, `FSTP_IDX_PHASE, dp_hi_ok_r)) begin
				hrdata_r <= {24'h00_0000, phase_r};
			end else begin
				hrdata_r <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register writes; the restart bit is self clearing and always reads zero
	// phase register: tx phase in bits 3:0, rx phase in bits 7:4
	// mux words: four bits per pin, first word for pins 3:0, second for pins 7:4

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			ctrl_r       <= `FSTP_RST_REG16;
			sync_ctrl_r  <= `FSTP_RST_REG16;
			mux_first_r  <= `FSTP_RST_REG16;
			mux_second_r <= `FSTP_RST_REG16;
			phase_r      <= 8'h00;
			restart_r    <= 1'b0;
		end else begin
			restart_r <= 1'b0;
			if (wr_en_w) begin
				if (hit(dp_idx_r, `FSTP_IDX_CTRL, dp_hi_ok_r)) begin
					ctrl_r <= hwdata_i[15:0];
					ctrl_r[`FSTP_RESTART_BIT] <= 1'b0;
					restart_r <= hwdata_i[`FSTP_RESTART_BIT];
				end
				if (hit(dp_idx_r, `FSTP_IDX_SYNC, dp_hi_ok_r)) begin
					sync_ctrl_r <= hwdata_i[15:0];
				end
				if (hit(dp_idx_r, `FSTP_IDX_MUX1, dp_hi_ok_r) && SMALL_PKG == 0) begin
					mux_first_r <= hwdata_i[15:0];
				end
				if (hit(dp_idx_r, `FSTP_IDX_MUX2, dp_hi_ok_r)) begin
					mux_second_r <= hwdata_i[15:0];
				end
				if (hit(dp_idx_r, `FSTP_IDX_PHASE, dp_hi_ok_r)) begin
					phase_r <= hwdata_i[7:0];
				end
			end
		end
	end

	assign link_restart_o = restart_r;

	////////////////////////////////////////////////////////////////////////////////
	// skew capture: taken once at the rise of a new link, held until it drops,
	// so the reported figure cannot drift within one link
	// the restart pulse only drops the report; the link side must take link_up_i
	// down and up again before a fresh figure is captured

	assign link_rise_w = link_up_i & ~link_up_d_r;
	// the limit is a parameter so that a build may clamp the reported figure
	assign skew_lim_w  = (align_skew_i > SKEW_LIMIT) ? SKEW_LIMIT : align_skew_i;

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			link_up_d_r    <= 1'b0;
			sync_init_r    <= 1'b0;
			sync_pending_r <= 1'b0;
			skew_valid_r   <= 1'b0;
			skew_master_r  <= 1'b0;
			skew_val_r     <= 4'h0;
		end else begin
			link_up_d_r <= link_up_i;
			// init value must be present; a new link after the write arms the report
			if (wr_en_w && hit(dp_idx_r, `FSTP_IDX_SYNC, dp_hi_ok_r)) begin
				sync_init_r    <= (hwdata_i[15:0] == `FSTP_SYNC_INIT_VAL);
				sync_pending_r <= (hwdata_i[15:0] == `FSTP_SYNC_INIT_VAL);
			end else if (link_rise_w) begin
				sync_pending_r <= 1'b0;
			end
			if (!link_up_i || restart_r) begin
				skew_valid_r <= 1'b0;
			end else if (link_rise_w) begin
				skew_valid_r  <= speed_1000_i & sync_init_r & sync_pending_r;
				skew_master_r <= master_mode_i;
				skew_val_r    <= skew_lim_w;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// frame start: rising edge of each line event gives one strobe per frame
	// a line held high for several cycles still gives one strobe; a fresh frame
	// needs the line to drop first

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tx_line_d_r <= 1'b0;
			rx_line_d_r <= 1'b0;
		end else begin
			tx_line_d_r <= transmit_frame_start_pulse_line_i;
			rx_line_d_r <= receive_frame_start_pulse_line_i;
		end
	end

	assign tx_strobe_w = transmit_frame_start_pulse_line_i & ~tx_line_d_r;
	assign rx_strobe_w = receive_frame_start_pulse_line_i & ~rx_line_d_r;

	fstp_phase_delay #(
		.PHASE_W (4),
		.CNT_W   (8)
	) u_tx_delay (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.strobe_i  (tx_strobe_w),
		.phase_i   (phase_r[`FSTP_PHASE_TX_LSB +: 4]),
		.pulse_o   (tx_pulse_w)
	);

	fstp_phase_delay #(
		.PHASE_W (4),
		.CNT_W   (8)
	) u_rx_delay (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.strobe_i  (rx_strobe_w),
		.phase_i   (phase_r[`FSTP_PHASE_RX_LSB +: 4]),
		.pulse_o   (rx_pulse_w)
	);

	assign transmit_frame_start_pulse_o = tx_pulse_w;
	assign receive_frame_start_pulse_o  = rx_pulse_w;

	// pins follow the pulses through one more flop, so pin timing is fixed
	fstp_pin_mux u_pin_mux (
		.sys_clk_i    (sys_clk_i),
		.sys_rst_i    (sys_rst_i),
		.sel_first_i  (mux_first_r),
		.sel_second_i (mux_second_r),
		.first_en_i   (SMALL_PKG == 0),
		.tx_pulse_i   (tx_pulse_w),
		.rx_pulse_i   (rx_pulse_w),
		.pins_o       (sfd_pins_o)
	);

endmodule // fstp_top

// [testbench/fstp_top_asserts.sv]
// checker for the frame start pulse block
// assumes it is bound to fstp_top and sees only its ports
module fstp_top_asserts (
	// clock, reset, bus
	input wire        sys_clk_i,
	input wire        sys_rst_i,
	input wire        hsel_i,
	input wire [31:0] haddr_i,
	input wire [1:0]  htrans_i,
	input wire        hwrite_i,
	input wire        hready_i,
	input wire [31:0] hwdata_i,
	input wire        hreadyout_o,
	input wire        hresp_o,
	// line and pulses
	input wire        transmit_frame_start_pulse_line_i,
	input wire        transmit_frame_start_pulse_o,
	input wire        receive_frame_start_pulse_o,
	input wire [7:0]  sfd_pins_o,
	input wire        link_restart_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	logic       tx_q_r;
	logic [5:0] tx_age_r;
	wire        addr_ok = hsel_i && htrans_i[1] && hready_i;
	////////////////////////////////////////////////////////////
	// age saturates so an old rise can never excuse a late pulse
	always @(posedge sys_clk_i) begin
		tx_q_r <= transmit_frame_start_pulse_line_i;
		if (sys_rst_i)
			tx_age_r <= 6'h3F;
		else if (transmit_frame_start_pulse_line_i && !tx_q_r)
			tx_age_r <= 6'h00;
		else if (tx_age_r != 6'h3F)
			tx_age_r <= tx_age_r + 6'h01;
	end
	a_tx_one_wide: assert property (transmit_frame_start_pulse_o |=> !transmit_frame_start_pulse_o)
		else $error("transmit pulse wider than one cycle");
	a_rx_one_wide: assert property (receive_frame_start_pulse_o |=> !receive_frame_start_pulse_o)
		else $error("receive pulse wider than one cycle");
	a_tx_has_cause: assert property (transmit_frame_start_pulse_o |-> tx_age_r < 6'h1F)
		else $error("transmit pulse without a recent line rise");
	a_pins_need_pulse: assert property (sfd_pins_o != 8'h00 |->
		$past(transmit_frame_start_pulse_o || receive_frame_start_pulse_o))
		else $error("pin active without a pulse one cycle before");
	a_resp_okay: assert property (hresp_o == 1'b0)
		else $error("bus response not okay");
	a_write_no_wait: assert property (addr_ok && hwrite_i |=> hreadyout_o)
		else $error("write data phase stalled");
	a_read_one_wait: assert property (addr_ok && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read data phase not one wait state");
	a_restart_pulse: assert property (addr_ok && hwrite_i && haddr_i == 32'h0000_007C ##1
		hwdata_i[14] |-> ##[1:2] link_restart_o)
		else $error("restart write gave no restart pulse");
	a_restart_single: assert property (link_restart_o |=> !link_restart_o)
		else $error("restart pulse wider than one cycle");
	cover property (transmit_frame_start_pulse_o);
	cover property (receive_frame_start_pulse_o);
	cover property (link_restart_o);
endmodule // fstp_top_asserts

// [testbench/fstp_ts_model.sv]
// far-end time stamp logic: counts the frame start strobes it receives
// assumes strobes are one cycle wide on sys_clk_i
module fstp_ts_model (
	input  wire        sys_clk_i,
	input  wire        sys_rst_i,
	input  wire        tx_pulse_i,
	input  wire        rx_pulse_i,
	output logic [7:0] tx_count_o,
	output logic [7:0] rx_count_o
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tx_count_o <= 8'h00;
			rx_count_o <= 8'h00;
		end else begin
			tx_count_o <= tx_count_o + {7'h00, tx_pulse_i === 1'b1};
			rx_count_o <= rx_count_o + {7'h00, rx_pulse_i === 1'b1};
		end
	end
endmodule // fstp_ts_model

// [testbench/fstp_top_tb.sv]
// self-checking bench for the frame start pulse block
// assumes fstp_top with default parameters plus a SMALL_PKG build, on one 250 MHz clock
module fstp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, hsel, hwrite, tx_line, rx_line, link_up, spd, mst;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [3:0]  skew;
	wire  [31:0] hrdata, hrdata_s;
	wire         hready, hresp, tx_p, rx_p, restart;
	wire  [7:0]  pins, pins_s, tx_n, rx_n;
	int          n_errors, cmp_count, n_rst;
	fstp_top fstp_top_i (.sys_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.transmit_frame_start_pulse_line_i(tx_line), .receive_frame_start_pulse_line_i(rx_line), .link_up_i(link_up),
		.speed_1000_i(spd), .master_mode_i(mst), .align_skew_i(skew),
		.transmit_frame_start_pulse_o(tx_p), .receive_frame_start_pulse_o(rx_p),
		.sfd_pins_o(pins), .link_restart_o(restart));
	// small package build on the same bus and lines; it follows the main slave's hready
	fstp_top #(.SMALL_PKG(1)) fstp_top_small_i (.sys_clk_i(clk), .sys_rst_i(rst),
		.hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
		.hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata_s), .hreadyout_o(),
		.hresp_o(), .transmit_frame_start_pulse_line_i(tx_line), .receive_frame_start_pulse_line_i(rx_line), .link_up_i(link_up),
		.speed_1000_i(spd), .master_mode_i(mst), .align_skew_i(skew),
		.transmit_frame_start_pulse_o(), .receive_frame_start_pulse_o(),
		.sfd_pins_o(pins_s), .link_restart_o());
	fstp_ts_model fstp_ts_model_i (.sys_clk_i(clk), .sys_rst_i(rst), .tx_pulse_i(tx_p),
		.rx_pulse_i(rx_p), .tx_count_o(tx_n), .rx_count_o(rx_n));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) if (restart === 1'b1) n_rst++;
	////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// one single transfer; waits on the slave, only the watchdog ends a hang
	task xfer(input logic [9:0] idx, input logic w, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {20'h0_0000, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task wr(input logic [9:0] idx, input logic [31:0] d);
		logic [31:0] q;
		xfer(idx, 1'b1, d, q);
	endtask
	task rd_chk(input logic [9:0] idx, input logic [31:0] e);
		logic [31:0] q;
		xfer(idx, 1'b0, 32'h0000_0000, q);
		chk(q, e);
	endtask
	////////////////////////////////////////////////////////////
	task t_regs;
		wr(10'h171, 32'h0000_0321);
		wr(10'h172, 32'h0000_1203);
		rd_chk(10'h171, 32'h0000_0321);
		chk(hrdata_s, 32'h0000_0000);
		rd_chk(10'h172, 32'h0000_1203);
		wr(10'h3FF, 32'h0000_ABCD);
		rd_chk(10'h3FF, 32'h0000_0000);
		rd_chk(10'h055, 32'h0000_0000);
	endtask
	// both lines rise together; pulses land 2*phase+1 cycles later
	task t_pulse(input logic [3:0] p, input logic [3:0] q);
		int          i, t_at, r_at;
		logic [7:0]  t0, r0;
		wr(10'h180, {24'h00_0000, q, p});
		rd_chk(10'h180, {24'h00_0000, q, p});
		t0 = tx_n;
		r0 = rx_n;
		t_at = 0;
		r_at = 0;
		@(posedge clk);
		tx_line <= 1'b1;
		rx_line <= 1'b1;
		for (i = 1; i <= 40; i++) begin
			@(posedge clk);
			if (i == 4) tx_line <= 1'b0;
			if (i == 4) rx_line <= 1'b0;
			#1;
			if (t_at != 0 && i == t_at + 1) chk({24'h00_0000, pins}, 32'h0000_0095);
			if (r_at != 0 && i == r_at + 1) chk({24'h00_0000, pins}, 32'h0000_0056);
			if (t_at != 0 && i == t_at + 1) chk({24'h00_0000, pins_s}, 32'h0000_0090);
			if (r_at != 0 && i == r_at + 1) chk({24'h00_0000, pins_s}, 32'h0000_0050);
			if (tx_p === 1'b1) t_at = i;
			if (rx_p === 1'b1) r_at = i;
		end
		chk(32'(t_at), 32'(2 * p + 1));
		chk(32'(r_at), 32'(2 * q + 1));
		chk({24'h00_0000, tx_n - t0}, 32'h0000_0001);
		chk({24'h00_0000, rx_n - r0}, 32'h0000_0001);
	endtask
	// a zero sync value skips the write, so the link forms unarmed
	task t_skew(input logic [15:0] sv, input logic s, input logic m, input logic [3:0] k,
		input logic [31:0] e);
		if (sv != 16'h0000) wr(10'h0E9, {16'h0000, sv});
		@(posedge clk);
		spd <= s;
		mst <= m;
		skew <= k;
		link_up <= 1'b1;
		@(posedge clk);
		skew <= 4'hF - k;
		rd_chk(10'h055, e);
		link_up <= 1'b0;
	endtask
	// link up before the sync write, so only the restart's new link arms the report
	task t_restart;
		@(posedge clk);
		spd <= 1'b1;
		mst <= 1'b1;
		skew <= 4'h5;
		link_up <= 1'b1;
		wr(10'h0E9, 32'h0000_DF22);
		rd_chk(10'h0E9, 32'h0000_DF22);
		rd_chk(10'h055, 32'h0000_0000);
		n_rst = 0;
		wr(10'h01F, 32'h0000_4000);
		repeat (3) @(posedge clk);
		chk(32'(n_rst), 32'h0000_0001);
		rd_chk(10'h01F, 32'h0000_0000);
		// far side answers the restart by dropping the link and forming it again
		link_up <= 1'b0;
		@(posedge clk);
		link_up <= 1'b1;
		rd_chk(10'h055, 32'h0000_8050);
		wr(10'h01F, 32'h0000_4000);
		rd_chk(10'h055, 32'h0000_0000);
		link_up <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		{hsel, hwrite, tx_line, rx_line, link_up, spd, mst} = 7'h00;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		htrans = 2'b00;
		skew = 4'h0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_regs;
		t_pulse(4'h0, 4'hF);
		t_pulse(4'h1, 4'hE);
		t_pulse(4'hF, 4'h0);
		t_skew(16'hDF22, 1'b1, 1'b1, 4'h2, 32'h0000_8020);
		t_skew(16'hDF22, 1'b1, 1'b0, 4'h1, 32'h0000_8001);
		t_skew(16'h0000, 1'b1, 1'b0, 4'h1, 32'h0000_0000);
		t_skew(16'h1234, 1'b1, 1'b1, 4'h3, 32'h0000_0000);
		t_skew(16'hDF22, 1'b0, 1'b1, 4'h3, 32'h0000_0000);
		t_restart;
		end_of_test;
	end
	initial begin
		#40000;
		n_errors++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		end_of_test;
	end
endmodule // fstp_top_tb
bind fstp_top fstp_top_asserts fstp_top_asserts_i (.sys_clk_i(sys_clk_i),
	.sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
	.hwrite_i(hwrite_i), .hready_i(hready_i), .hwdata_i(hwdata_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .transmit_frame_start_pulse_line_i(transmit_frame_start_pulse_line_i),
	.transmit_frame_start_pulse_o(transmit_frame_start_pulse_o),
	.receive_frame_start_pulse_o(receive_frame_start_pulse_o), .sfd_pins_o(sfd_pins_o),
	.link_restart_o(link_restart_o));
